// ### design/perf_counters.sv
/*
  perf_counters: hardware performance monitor of the core. Holds the
  cycle counter, the retired instruction counter, a build-time number of
  event counters with selectors, and the counter inhibit register.
  Assumes clk_sys_i is the core's gated clock, so sleep stops all counting,
  and that the core presents one register access per cycle on the csr port.
*/
//
// Contract
// - every counter, cycle, retire and event, is 64 bits wide.
// - event counter count is a build parameter, 0 to 29, default 1.
// - positions not built read back as zero.
// - all counters run on the gated core clock and pause in sleep.
// - selector bits 0..15 name cycles, retire, hazards, memory, jumps, coprocessor.
// - a set selector bit makes its counter count that event.
// - a zero selector makes its counter count nothing.
// - all implemented counters come out of reset inhibited.
// - inhibit at 0x320: bit 0 cycle, bit 2 retire, bit x counter x.
// - low half through the base register, high half through the high one.
// - reading any counter half leaves the counter untouched.
// - cycle and retire counters always exist.
// - cycle counter counts cycles, retire counter counts retired instructions.
// - each event counter adds 64 count flops, selector, inhibit flop, adder.
// - all registers but the read-only 0xC00 and 0xC80 aliases take write, set and clear accesses, register or immediate.
`timescale 1ns/100ps
module perf_counters
  import perf_counter_pkg::*;
#(
  parameter int unsigned EVENT_COUNTER_COUNT_PARAM = 1
)(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // register access from the core
  input  wire logic        csr_access_i,
  input  wire logic [11:0] csr_addr_i,
  input  wire logic [1:0]  csr_op_i,
  input  wire logic [31:0] csr_wdata_i,
  output logic      [31:0] csr_rdata_o,
  // pipeline event sources, one-cycle pulses or levels per cycle
  input  wire logic        retire_event_i,
  input  wire logic        load_use_hazard_event_i,
  input  wire logic        jump_register_hazard_event_i,
  input  wire logic        fetch_wait_event_i,
  input  wire logic        memory_read_event_i,
  input  wire logic        memory_write_event_i,
  input  wire logic        unconditional_jump_event_i,
  input  wire logic        conditional_transfer_event_i,
  input  wire logic        conditional_taken_event_i,
  input  wire logic        compressed_retire_event_i,
  input  wire logic        pipeline_stall_event_i,
  input  wire logic        coproc_type_conflict_event_i,
  input  wire logic        coproc_contention_event_i,
  input  wire logic        coproc_dependency_event_i,
  input  wire logic        coproc_writeback_event_i
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] inhibit;
    logic [63:0] cycle;
    logic [63:0] retire;
    logic [31:0] rdata;
  } top_state_type;

  // inhibit bits that physically exist; the rest stay zero
  localparam logic [31:0] INHIBIT_BUILT_MASK = INHIBIT_FIXED_MASK |
    (((32'h0000_0001 << EVENT_COUNTER_COUNT_PARAM) - 32'h0000_0001) << FIRST_EVENT_CTR);

  top_state_type state_reg;
  top_state_type state_next;

  logic [15:0] event_vec;
  logic [6:0]  addr_group;
  logic [4:0]  addr_index;
  logic        do_write;
  logic [31:0] old_value;
  logic [31:0] new_value;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_sel;
  logic        cycle_written;
  logic        retire_written;
  logic [63:0] ev_count  [32];
  logic [15:0] ev_select [32];

  // ------------------------------------------------------------------
  // event vector in selector bit order
  // ------------------------------------------------------------------
  // bit 0 is high every cycle; the gated clock already drops sleep cycles
  always_comb begin
    event_vec                 = 16'h0000;
    event_vec[EV_CYCLE]       = 1'b1;
    event_vec[EV_RETIRE]      = retire_event_i;
    event_vec[EV_LOAD_USE]    = load_use_hazard_event_i;
    event_vec[EV_JUMP_REG]    = jump_register_hazard_event_i;
    event_vec[EV_FETCH_WAIT]  = fetch_wait_event_i;
    event_vec[EV_MEM_READ]    = memory_read_event_i;
    event_vec[EV_MEM_WRITE]   = memory_write_event_i;
    event_vec[EV_UNCOND_JUMP] = unconditional_jump_event_i;
    event_vec[EV_COND_XFER]   = conditional_transfer_event_i;
    event_vec[EV_COND_TAKEN]  = conditional_taken_event_i;
    event_vec[EV_COMPRESSED]  = compressed_retire_event_i;
    event_vec[EV_PIPE_STALL]  = pipeline_stall_event_i;
    event_vec[EV_COPROC_TYPE] = coproc_type_conflict_event_i;
    event_vec[EV_COPROC_CONT] = coproc_contention_event_i;
    event_vec[EV_COPROC_DEP]  = coproc_dependency_event_i;
    event_vec[EV_COPROC_WB]   = coproc_writeback_event_i;
  end

  // ------------------------------------------------------------------
  // event counter slices, one generate position per counter number
  // ------------------------------------------------------------------
  assign addr_group = csr_addr_i[11:5];
  assign addr_index = csr_addr_i[4:0];

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_slot
      if (gi >= FIRST_EVENT_CTR && gi < FIRST_EVENT_CTR + EVENT_COUNTER_COUNT_PARAM) begin : g_on
        event_counter_slice u_slice (
          .clk_sys_i   (clk_sys_i),
          .sys_rst_i   (sys_rst_i),
          .count_en_i  (!state_reg.inhibit[gi]),
          .event_vec_i (event_vec),
          .wr_lo_i     (wr_cnt_lo && addr_index == 5'(gi)),
          .wr_hi_i     (wr_cnt_hi && addr_index == 5'(gi)),
          .wr_sel_i    (wr_sel && addr_index == 5'(gi)),
          .wr_data_i   (new_value),
          .count_o     (ev_count[gi]),
          .select_o    (ev_select[gi])
        );
      end else begin : g_off
        // slots never built tie to zero so reads return zero
        assign ev_count[gi]  = COUNTER_RESET;
        assign ev_select[gi] = SELECTOR_RESET;
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // read decode; cycle and retire override their slots
  // ------------------------------------------------------------------
  always_comb begin
    old_value = WORD_ZERO;
    case (addr_group)
      GROUP_COUNT_LO, GROUP_ALIAS_LO: begin
        if (addr_index == CYCLE_INDEX) begin
          old_value = state_reg.cycle[31:0];
        end else if (addr_index == RETIRE_INDEX) begin
          old_value = state_reg.retire[31:0];
        end else begin
          old_value = ev_count[addr_index][31:0];
        end
      end
      GROUP_COUNT_HI, GROUP_ALIAS_HI: begin
        if (addr_index == CYCLE_INDEX) begin
          old_value = state_reg.cycle[63:32];
        end else if (addr_index == RETIRE_INDEX) begin
          old_value = state_reg.retire[63:32];
        end else begin
          old_value = ev_count[addr_index][63:32];
        end
      end
      GROUP_SELECTOR: begin
        if (addr_index == 5'h00) begin
          old_value = state_reg.inhibit;
        end else begin
          old_value = {16'h0000, ev_select[addr_index]};
        end
      end
      default: begin
        old_value = WORD_ZERO;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // write merge for write, set and clear forms
  // ------------------------------------------------------------------
  // immediate forms arrive already zero-extended in csr_wdata_i
  always_comb begin
    case (csr_op_type'(csr_op_i))
      CSR_OP_WRITE: new_value = csr_wdata_i;
      CSR_OP_SET:   new_value = old_value | csr_wdata_i;
      CSR_OP_CLEAR: new_value = old_value & ~csr_wdata_i;
      default:      new_value = old_value;
    endcase
  end

  // plain reads never reach a write strobe, so they cannot disturb a count
  assign do_write  = csr_access_i && csr_op_type'(csr_op_i) != CSR_OP_READ;
  assign wr_cnt_lo = do_write && addr_group == GROUP_COUNT_LO;
  assign wr_cnt_hi = do_write && addr_group == GROUP_COUNT_HI;
  assign wr_sel    = do_write && addr_group == GROUP_SELECTOR && addr_index != 5'h00;
  assign cycle_written  = (wr_cnt_lo || wr_cnt_hi) && addr_index == CYCLE_INDEX;
  assign retire_written = (wr_cnt_lo || wr_cnt_hi) && addr_index == RETIRE_INDEX;

  // ------------------------------------------------------------------
  // next state for inhibit, cycle, retire and read data
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!state_reg.inhibit[INHIBIT_CYCLE_BIT] && !cycle_written) begin
      state_next.cycle = state_reg.cycle + 64'h0000_0000_0000_0001;
    end
    if (!state_reg.inhibit[INHIBIT_RETIRE_BIT] && retire_event_i && !retire_written) begin
      state_next.retire = state_reg.retire + 64'h0000_0000_0000_0001;
    end
    // a written counter skips its increment, so no carry leaks into the other half
    if (wr_cnt_lo && addr_index == CYCLE_INDEX) begin
      state_next.cycle[31:0] = new_value;
    end
    if (wr_cnt_hi && addr_index == CYCLE_INDEX) begin
      state_next.cycle[63:32] = new_value;
    end
    if (wr_cnt_lo && addr_index == RETIRE_INDEX) begin
      state_next.retire[31:0] = new_value;
    end
    if (wr_cnt_hi && addr_index == RETIRE_INDEX) begin
      state_next.retire[63:32] = new_value;
    end
    if (do_write && csr_addr_i == COUNTER_INHIBIT_ADDR) begin
      state_next.inhibit = new_value & INHIBIT_BUILT_MASK;
    end
    // read data shows the value before any write of the same access
    if (csr_access_i) begin
      state_next.rdata = old_value;
    end
  end

  // every built counter starts inhibited to save power
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= '{inhibit: INHIBIT_BUILT_MASK, cycle: COUNTER_RESET,
                     retire: COUNTER_RESET, rdata: WORD_ZERO};
    end else begin
      state_reg <= state_next;
    end
  end

  assign csr_rdata_o = state_reg.rdata;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_reset_inhibits;
    @(posedge clk_sys_i) sys_rst_i |=> state_reg.inhibit == INHIBIT_BUILT_MASK;
  endproperty
  a_reset_inhibits: assert property (p_reset_inhibits)
    else $error("counters not all inhibited after reset");

  property p_cycle_counts;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!state_reg.inhibit[INHIBIT_CYCLE_BIT] && !cycle_written)
        |=> state_reg.cycle == $past(state_reg.cycle) + 64'h0000_0000_0000_0001;
  endproperty
  a_cycle_counts: assert property (p_cycle_counts)
    else $error("cycle counter did not advance by one");

  property p_inhibited_holds;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_reg.inhibit[INHIBIT_CYCLE_BIT] && !cycle_written) |=> $stable(state_reg.cycle);
  endproperty
  a_inhibited_holds: assert property (p_inhibited_holds)
    else $error("inhibited cycle counter moved");

  property p_retire_counts;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!retire_written) |=> state_reg.retire == $past(state_reg.retire) +
        64'($past(retire_event_i && !state_reg.inhibit[INHIBIT_RETIRE_BIT]));
  endproperty
  a_retire_counts: assert property (p_retire_counts)
    else $error("retire counter does not follow retirements");

  property p_write_wins;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_cnt_lo && addr_index == CYCLE_INDEX) |=> state_reg.cycle[31:0] == $past(new_value);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("cycle low write lost to increment");

  property p_high_half_read;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (csr_access_i && addr_group == GROUP_COUNT_HI && addr_index == CYCLE_INDEX)
        |=> csr_rdata_o == $past(state_reg.cycle[63:32]);
  endproperty
  a_high_half_read: assert property (p_high_half_read)
    else $error("high half read returned wrong word");

  property p_unbuilt_reads_zero;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (csr_access_i && addr_group == GROUP_COUNT_LO &&
       32'(addr_index) >= FIRST_EVENT_CTR + EVENT_COUNTER_COUNT_PARAM) |=> csr_rdata_o == WORD_ZERO;
  endproperty
  a_unbuilt_reads_zero: assert property (p_unbuilt_reads_zero)
    else $error("unbuilt counter read nonzero");

  property p_inhibit_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (do_write && csr_addr_i == COUNTER_INHIBIT_ADDR)
        |=> state_reg.inhibit == ($past(new_value) & INHIBIT_BUILT_MASK);
  endproperty
  a_inhibit_write: assert property (p_inhibit_write)
    else $error("inhibit register did not take write");

  property p_read_no_effect;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (csr_access_i && !do_write && state_reg.inhibit[INHIBIT_CYCLE_BIT]) |=> $stable(state_reg.cycle);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("read disturbed the cycle counter");

  c_low_carry: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_reg.cycle[31:0] == 32'hFFFF_FFFF ##1 state_reg.cycle[31:0] == 32'h0000_0000);
  c_enable_cycle: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    do_write && csr_addr_i == COUNTER_INHIBIT_ADDR && !new_value[INHIBIT_CYCLE_BIT]);
  c_write_during_count: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_cnt_hi && addr_index == RETIRE_INDEX && retire_event_i);

endmodule

// ### design/perf_counter_pkg.sv
/*
  perf_counter_pkg: register numbers, field positions, reset values and
  event bit positions shared by the performance counter block and its
  event counter slice.
  Assumes the core's register access port carries a 12-bit register number.
*/
package perf_counter_pkg;

  // ------------------------------------------------------------------
  // widths and sizing
  // ------------------------------------------------------------------
  localparam int unsigned COUNTER_WIDTH   = 64;
  localparam int unsigned HALF_WIDTH      = 32;
  localparam int unsigned EVENT_WIDTH     = 16;
  localparam int unsigned CSR_ADDR_WIDTH  = 12;
  localparam int unsigned MAX_EVENT_CTRS  = 29;
  localparam int unsigned FIRST_EVENT_CTR = 3;

  // ------------------------------------------------------------------
  // register numbers; counter x sits at group base plus x
  // ------------------------------------------------------------------
  localparam logic [11:0] COUNTER_INHIBIT_ADDR = 12'h320;
  localparam logic [6:0]  GROUP_SELECTOR       = 7'h19;  // 0x320..0x33F
  localparam logic [6:0]  GROUP_COUNT_LO       = 7'h58;  // 0xB00..0xB1F
  localparam logic [6:0]  GROUP_COUNT_HI       = 7'h5C;  // 0xB80..0xB9F
  localparam logic [6:0]  GROUP_ALIAS_LO       = 7'h60;  // 0xC00..0xC1F, read only
  localparam logic [6:0]  GROUP_ALIAS_HI       = 7'h64;  // 0xC80..0xC9F, read only
  localparam logic [4:0]  CYCLE_INDEX          = 5'h00;
  localparam logic [4:0]  RETIRE_INDEX         = 5'h02;

  // ------------------------------------------------------------------
  // inhibit bit positions and values after reset
  // ------------------------------------------------------------------
  localparam int unsigned INHIBIT_CYCLE_BIT  = 0;
  localparam int unsigned INHIBIT_RETIRE_BIT = 2;
  localparam logic [31:0] INHIBIT_FIXED_MASK = 32'h0000_0005;
  localparam logic [63:0] COUNTER_RESET      = 64'h0000_0000_0000_0000;
  localparam logic [15:0] SELECTOR_RESET     = 16'h0000;
  localparam logic [31:0] WORD_ZERO          = 32'h0000_0000;

  // ------------------------------------------------------------------
  // event selector bit positions
  // ------------------------------------------------------------------
  localparam int unsigned EV_CYCLE         = 0;
  localparam int unsigned EV_RETIRE        = 1;
  localparam int unsigned EV_LOAD_USE      = 2;
  localparam int unsigned EV_JUMP_REG      = 3;
  localparam int unsigned EV_FETCH_WAIT    = 4;
  localparam int unsigned EV_MEM_READ      = 5;
  localparam int unsigned EV_MEM_WRITE     = 6;
  localparam int unsigned EV_UNCOND_JUMP   = 7;
  localparam int unsigned EV_COND_XFER     = 8;
  localparam int unsigned EV_COND_TAKEN    = 9;
  localparam int unsigned EV_COMPRESSED    = 10;
  localparam int unsigned EV_PIPE_STALL    = 11;
  localparam int unsigned EV_COPROC_TYPE   = 12;
  localparam int unsigned EV_COPROC_CONT   = 13;
  localparam int unsigned EV_COPROC_DEP    = 14;
  localparam int unsigned EV_COPROC_WB     = 15;

  // ------------------------------------------------------------------
  // register access operations
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CSR_OP_READ  = 2'b00,
    CSR_OP_WRITE = 2'b01,
    CSR_OP_SET   = 2'b10,
    CSR_OP_CLEAR = 2'b11
  } csr_op_type;

endpackage

// ### design/event_counter_slice.sv
/*
  event_counter_slice: one 64-bit event counter with its event selector.
  Assumes the parent decodes register accesses and hands over one-cycle
  write strobes with the already merged write data.
*/
`timescale 1ns/100ps
module event_counter_slice
  import perf_counter_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // control from the parent
  input  wire logic        count_en_i,
  input  wire logic [15:0] event_vec_i,
  input  wire logic        wr_lo_i,
  input  wire logic        wr_hi_i,
  input  wire logic        wr_sel_i,
  input  wire logic [31:0] wr_data_i,
  // state out
  output logic      [63:0] count_o,
  output logic      [15:0] select_o
);

  typedef struct packed {
    logic [63:0] count;
    logic [15:0] select;
  } slice_state_type;

  slice_state_type state_reg;
  slice_state_type state_next;
  logic            hit;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // several selector bits set simply OR their events; software must avoid it
  // a write to either half suppresses the whole increment, carry included
  always_comb begin
    state_next = state_reg;
    hit        = count_en_i && |(state_reg.select & event_vec_i);
    if (hit && !wr_lo_i && !wr_hi_i) begin
      state_next.count = state_reg.count + 64'h0000_0000_0000_0001;
    end
    if (wr_lo_i) begin
      state_next.count[31:0] = wr_data_i;
    end
    if (wr_hi_i) begin
      state_next.count[63:32] = wr_data_i;
    end
    if (wr_sel_i) begin
      state_next.select = wr_data_i[15:0];
    end
  end

  // counter and selector are cleared so a fresh core counts nothing
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= '{count: COUNTER_RESET, select: SELECTOR_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_o  = state_reg.count;
  assign select_o = state_reg.select;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_zero_select_holds;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_reg.select == SELECTOR_RESET && !wr_lo_i && !wr_hi_i) |=> $stable(count_o);
  endproperty
  a_zero_select_holds: assert property (p_zero_select_holds)
    else $error("counter moved with an empty selector");

  property p_selected_event_counts;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (count_en_i && (event_vec_i & state_reg.select) != 16'h0000 && !wr_lo_i && !wr_hi_i)
        |=> count_o == $past(count_o) + 64'h0000_0000_0000_0001;
  endproperty
  a_selected_event_counts: assert property (p_selected_event_counts)
    else $error("selected event was not counted");

endmodule

// ### verif/perf_counters_tb_top.sv
/*
  perf_counters_tb_top: self-checking bench with a behavioural model of the
  counters, compared with the read data at every falling edge.
  Assumes read data returns the pre-write value one cycle after an access.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
  $display("BAD %s exp %h seen %h", nm, e, s); end end
module perf_counters_tb_top;
  import perf_counter_pkg::*;
  localparam int          N    = 2;
  localparam logic [31:0] MASK = 32'h0000_0005 | (((32'h1 << N) - 32'h1) << 3);
  // ----------------------
  // stimulus and model
  // ----------------------
  logic        clk_sys_i  = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        csr_access = 1'b0;
  logic [11:0] csr_addr   = 12'h000;
  logic [1:0]  csr_op     = 2'b00;
  logic [31:0] csr_wdata  = 32'h0000_0000;
  logic [14:0] ev_vec     = 15'h0000;
  logic [31:0] csr_rdata;
  logic [63:0] m_cnt [0:31];
  logic [15:0] m_sel [0:31];
  logic [31:0] m_inh;
  logic [31:0] exp_rd;
  integer      seed        = 32'h555BFF01;
  int          miscompares = 0;
  int          checked     = 0;
  int          k;

  perf_counters #(.EVENT_COUNTER_COUNT_PARAM(N)) perf_counters_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .csr_access_i(csr_access),
    .csr_addr_i(csr_addr), .csr_op_i(csr_op), .csr_wdata_i(csr_wdata),
    .csr_rdata_o(csr_rdata), .retire_event_i(ev_vec[0]),
    .load_use_hazard_event_i(ev_vec[1]), .jump_register_hazard_event_i(ev_vec[2]),
    .fetch_wait_event_i(ev_vec[3]), .memory_read_event_i(ev_vec[4]),
    .memory_write_event_i(ev_vec[5]), .unconditional_jump_event_i(ev_vec[6]),
    .conditional_transfer_event_i(ev_vec[7]), .conditional_taken_event_i(ev_vec[8]),
    .compressed_retire_event_i(ev_vec[9]), .pipeline_stall_event_i(ev_vec[10]),
    .coproc_type_conflict_event_i(ev_vec[11]), .coproc_contention_event_i(ev_vec[12]),
    .coproc_dependency_event_i(ev_vec[13]), .coproc_writeback_event_i(ev_vec[14]));

  function automatic logic built(input logic [4:0] x);
    return (x == 5'h00) || (x == 5'h02) || (x >= 5'h03 && x < 5'(3 + N));
  endfunction
  // unbuilt slots and stray addresses answer zero
  function logic [31:0] mread(input logic [11:0] a);
    if (a == COUNTER_INHIBIT_ADDR) return m_inh;
    if (!built(a[4:0])) return WORD_ZERO;
    if (a[11:5] == GROUP_SELECTOR && a[4:0] > 5'h02) return {16'h0000, m_sel[a[4:0]]};
    if (a[11:5] == GROUP_COUNT_LO || a[11:5] == GROUP_ALIAS_LO) return m_cnt[a[4:0]][31:0];
    if (a[11:5] == GROUP_COUNT_HI || a[11:5] == GROUP_ALIAS_HI) return m_cnt[a[4:0]][63:32];
    return WORD_ZERO;
  endfunction
  function automatic logic [11:0] pick(input logic [31:0] r);
    logic [11:0] t [0:7] = '{12'h320, 12'h323, 12'h324, 12'hB00,
                             12'hB02, 12'hC03, 12'hB84, 12'hC85};
    return r[31] ? r[11:0] : t[r[2:0]];
  endfunction

  // model: increments use the settings from before this edge's write
  always @(posedge clk_sys_i) begin
    logic [31:0] nv;
    logic [31:0] inc;
    int          wx;
    wx = -1;
    for (int i = 0; i < 32; i++) begin
      inc[i] = built(5'(i)) && !m_inh[i] && (i == 0 ? 1'b1 : i == 2 ? ev_vec[0] :
               |(m_sel[i] & {ev_vec, 1'b1}));
    end
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        m_cnt[i] = COUNTER_RESET;
        m_sel[i] = SELECTOR_RESET;
      end
      m_inh = MASK;
      exp_rd = WORD_ZERO;
    end else begin
      if (csr_access) begin
        exp_rd = mread(csr_addr);
        nv = csr_op == CSR_OP_WRITE ? csr_wdata : csr_op == CSR_OP_SET ?
             exp_rd | csr_wdata : exp_rd & ~csr_wdata;
        if (csr_op != CSR_OP_READ && csr_addr == COUNTER_INHIBIT_ADDR) begin
          m_inh = nv & MASK;
        end else if (csr_op != CSR_OP_READ && built(csr_addr[4:0])) begin
          wx = int'(csr_addr[4:0]);
          case (csr_addr[11:5])
            GROUP_SELECTOR: begin
              if (wx > 2) m_sel[wx] = nv[15:0];
              wx = -1;
            end
            GROUP_COUNT_LO: m_cnt[wx][31:0] = nv;
            GROUP_COUNT_HI: m_cnt[wx][63:32] = nv;
            default: wx = -1;
          endcase
        end
      end
      for (int i = 0; i < 32; i++) if (inc[i] && i != wx) m_cnt[i] = m_cnt[i] + 64'h1;
    end
  end

  always #4 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) ev_vec <= 15'($random(seed));
  always @(negedge clk_sys_i) `CHK("csr_rdata", exp_rd, csr_rdata)

  // ----------------------
  // access tasks
  // ----------------------
  task automatic acc(input logic [11:0] a, input logic [1:0] op, input logic [31:0] d);
    @(negedge clk_sys_i);
    csr_access <= 1'b1;
    csr_addr <= a;
    csr_op <= op;
    csr_wdata <= d;
  endtask
  task automatic rd(input int n);
    repeat (n) acc(pick(32'($random(seed))), CSR_OP_READ, 32'($random(seed)));
    @(negedge clk_sys_i);
    csr_access <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #160000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i) sys_rst_i <= 1'b0;
    rd(16);
    $display("test reset_values done");
    acc(COUNTER_INHIBIT_ADDR, CSR_OP_CLEAR, 32'hFFFF_FFFF);
    for (k = 0; k < 16; k++) begin
      acc(12'h323, CSR_OP_WRITE, 32'h0000_0000);
      acc(12'h323, CSR_OP_SET, 32'h1 << k);
      acc(12'h324, CSR_OP_WRITE, 32'h1 << (32'($random(seed)) & 32'hF));
      rd(12);
    end
    $display("test event_select done");
    acc(COUNTER_INHIBIT_ADDR, CSR_OP_SET, 32'h0000_0005);
    rd(8);
    acc(COUNTER_INHIBIT_ADDR, CSR_OP_WRITE, 32'hFFFF_FFFF);
    acc(12'hB00, CSR_OP_WRITE, 32'hFFFF_FFFE);
    acc(12'hB80, CSR_OP_WRITE, 32'h0000_0007);
    acc(12'hB83, CSR_OP_WRITE, 32'hFFFF_FFFF);
    acc(12'hC00, CSR_OP_WRITE, 32'h0000_0005);
    acc(12'hB01, CSR_OP_WRITE, 32'h0000_0005);
    acc(COUNTER_INHIBIT_ADDR, CSR_OP_CLEAR, 32'h0000_0009);
    repeat (3) acc(12'hB00, CSR_OP_READ, 32'h0000_0000);
    acc(12'hB80, CSR_OP_READ, 32'h0000_0000);
    acc(12'hC83, CSR_OP_READ, 32'h0000_0000);
    acc(12'hB05, CSR_OP_READ, 32'h0000_0000);
    acc(12'hB00, CSR_OP_WRITE, 32'h0000_0010);
    rd(6);
    $display("test carry_and_write done");
    rd(200);
    $display("test random_reads done");
    @(negedge clk_sys_i) sys_rst_i <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(16);
    $display("test second_reset done");
    print_verdict();
  end
endmodule
